// >>> testbench/mdol_drv_model.sv
// mdol_drv_model: driver side of the position readout handshake
`default_nettype none
module mdol_drv_model #(
  parameter logic [3:0] WORD = 4'hb
) (
  input  wire logic clk_i,
  input  wire logic req_i,
  input  wire logic strobe_i,
  output logic      ready_o,
  output logic      bit_zero_o,
  output logic      bit_one_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] sh;
  logic [2:0] dly;
  logic       str_q;
  initial begin
    ready_o    = 1'b0;
    bit_zero_o = 1'b0;
    bit_one_o  = 1'b0;
    str_q      = 1'b0;
  end
  // answer late on purpose; released data lines toggle so a stale value never passes
  always @(posedge clk_i) begin
    str_q <= strobe_i;
    if (!req_i) begin
      dly     <= 3'h0;
      ready_o <= 1'b0;
      sh      <= WORD;
      {bit_one_o, bit_zero_o} <= ~{bit_one_o, bit_zero_o};
    end else begin
      if (dly != 3'h5) dly <= dly + 3'h1;
      ready_o <= (dly == 3'h5);
      if (dly == 3'h4) {bit_one_o, bit_zero_o} <= sh[3:2];
      // next pair once the strobe drops, well ahead of the next high phase
      if (str_q && !strobe_i) begin
        sh <= {sh[1:0], 2'h0};
        {bit_one_o, bit_zero_o} <= sh[1:0];
      end
    end
  end
endmodule : mdol_drv_model
`default_nettype wire

// >>> testbench/tb.sv
// tb: self-checking bench for the motor driver output logic
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DEVIATION_CLEAR_OUT = 2;
  logic                    clk_i = 1'b0;
  logic                    rst_i = 1'b1;
  logic [7:0]              addr_i = 8'h00;
  logic [31:0]             wdata_i = 32'h0;
  logic                    we_i = 1'b0;
  logic                    re_i = 1'b0;
  logic [31:0]             rdata_o;
  mdol_pkg::mdol_pin_in_t  pin_r = '0;
  mdol_pkg::mdol_pin_in_t  pins_i;
  mdol_pkg::mdol_bus_req_t fbus_i = '0;
  logic                    alarm_active_i = 1'b0;
  logic                    homing_active_i = 1'b0;
  mdol_pkg::mdol_drv_out_t drv_o;
  logic                    rdy, b0, b1, a_q, b_q, s_q;
  logic [31:0]             d;
  int miscompares = 0;
  int n_tests = 0;
  int ra = 0, rb = 0, rs = 0, run = 0, wid = 0, clr = 0, n0, n1;
  logic [15:0] cv [9] = '{16'h1, 16'h9, 16'h15, 16'h25, 16'h205, 16'h405, 16'h805,
                          16'h1005, 16'h4};
  logic [13:0] ev [9] = '{14'h2000, 14'h2206, 14'h100e, 14'h1007, 14'h1106, 14'h1086,
                          14'h1026, 14'h1016, 14'h1006};
  int rates [4] = '{4, 300, 398, 400};
  int wids [4] = '{2, 150, 199, 200};

  always #50 clk_i = ~clk_i;
  // readout pins come from the driver model, the rest from the bench
  always_comb begin
    pins_i = pin_r;
    pins_i.readout_ready_in = rdy;
    pins_i.position_bit_zero = b0;
    pins_i.position_bit_one = b1;
  end

  mdol_motor_driver_output_logic #(.DCL_WIDTH(DEVIATION_CLEAR_OUT), .RD_HALF(4), .RD_PAIRS(2),
    .STARTUP_CURRENT(1'b1), .STARTUP_RES(1'b0)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
    .pins_i(pins_i), .fbus_i(fbus_i), .alarm_active_i(alarm_active_i),
    .homing_active_i(homing_active_i), .drv_o(drv_o));
  mdol_drv_model drv (.clk_i(clk_i), .req_i(drv_o.position_request),
    .strobe_i(drv_o.shift_strobe), .ready_o(rdy), .bit_zero_o(b0), .bit_one_o(b1));

  // edge counters, clear-pin high-cycle count and last high width, read as deltas so only this process writes them
  always @(posedge clk_i) begin
    a_q <= drv_o.step_a;
    b_q <= drv_o.step_b;
    s_q <= drv_o.shift_strobe;
    if (drv_o.step_a === 1'b1 && a_q === 1'b0) ra <= ra + 1;
    if (drv_o.step_b === 1'b1 && b_q === 1'b0) rb <= rb + 1;
    if (drv_o.shift_strobe === 1'b1 && s_q === 1'b0) rs <= rs + 1;
    run <= (drv_o.step_a === 1'b1) ? run + 1 : 0;
    if (drv_o.step_a === 1'b0 && a_q === 1'b1) wid <= run;
    if (drv_o.alarm_reset === 1'b1) clr <= clr + 1;
  end

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    we_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_i);
    re_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1 v = rdata_o;
  endtask : rd
  task automatic st(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : st
  // poll a status bit until it drops, bounded
  task automatic wait_low(input int b);
    logic [31:0] v;
    for (int i = 0; i < 3000; i++) begin
      rd(mdol_pkg::ADDR_STATUS, v);
      if (v[b] === 1'b0) return;
    end
    miscompares++;
    $display("Error at %0t: status bit %0d stuck", $time, b);
    close_out();
  endtask : wait_low
  task automatic clr_cmd(input logic alm, input logic [31:0] c, input int exp);
    alarm_active_i <= alm;
    n0 = clr;
    wr(mdol_pkg::ADDR_CMD, c);
    st(8);
    chk(clr - n0, exp, "clear pulse");
  endtask : clr_cmd
  task automatic move(input logic [31:0] c, input int rate, input logic [31:0] m);
    wr(mdol_pkg::ADDR_CTRL, c);
    wr(mdol_pkg::ADDR_RATE, rate);
    n0 = ra;
    n1 = rb;
    wr(mdol_pkg::ADDR_MOVE, m);
    wait_low(0);
    st(4);
  endtask : move

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(mdol_pkg::ADDR_CTRL, d);
    chk(d, 32'h5, "ctrl after reset");
    chk(drv_o[13:0], 14'h1006, "levels after reset");
    // control bits one at a time against the full set of level outputs
    wr(mdol_pkg::ADDR_HOMING, 32'hc);
    for (int i = 0; i < 9; i++) begin
      wr(mdol_pkg::ADDR_CTRL, cv[i]);
      st(4);
      chk(drv_o[13:0], ev[i], "levels");
    end
    wr(mdol_pkg::ADDR_HOMING, 32'hb);
    wr(mdol_pkg::ADDR_CTRL, 32'h205);
    st(4);
    chk(drv_o[13:0], 14'h1006, "home start off type");
    fbus_i.current_off <= 1'b1;
    st(4);
    chk(drv_o[13:0], 14'h2000, "fieldbus current off");
    fbus_i <= '0;
    wr(mdol_pkg::ADDR_CTRL, 32'h105);
    st(6);
    chk(drv_o[13:0], 14'h2000, "enable pin low");
    pin_r.current_enable <= 1'b1;
    st(6);
    chk(drv_o[13:0], 14'h1006, "enable pin high");
    pin_r.free <= 1'b1;
    pin_r.torque_limit <= 1'b1;
    st(6);
    chk(drv_o[13:0], 14'h120e, "free and limit pins");
    pin_r.free <= 1'b0;
    pin_r.torque_limit <= 1'b0;
    fbus_i.free <= 1'b1;
    st(6);
    chk(drv_o[13:0], 14'h1206, "fieldbus free");
    fbus_i <= '0;
    // step formats, direction and on-time
    move(32'h5, 4, 32'h10003);
    chk(ra - n0, 3, "single steps");
    chk(drv_o.step_b, 1'b1, "dir cw");
    move(32'h5, 4, 32'h2);
    chk(drv_o.step_b, 1'b0, "dir ccw");
    move(32'h4, 4, 32'h10003);
    chk(ra - n0, 3, "dual cw a");
    chk(rb - n1, 0, "dual cw b");
    move(32'h4, 4, 32'h3);
    chk(ra - n0, 0, "dual ccw a");
    chk(rb - n1, 3, "dual ccw b");
    for (int i = 0; i < 4; i++) begin
      move(32'h5, rates[i], 32'h10001);
      chk(wid, wids[i], "on time");
    end
    move(32'h7, 4, 32'h10002);
    chk({drv_o.step_a, drv_o.step_b}, 2'b10, "inverted idle");
    // alarm clear and deviation clear sources
    wr(mdol_pkg::ADDR_CTRL, 32'h5);
    clr_cmd(1'b1, 32'h1, DEVIATION_CLEAR_OUT);
    clr_cmd(1'b1, 32'h2, 0);
    clr_cmd(1'b0, 32'h2, DEVIATION_CLEAR_OUT);
    clr_cmd(1'b0, 32'h4, DEVIATION_CLEAR_OUT);
    // level sources of the shared clear pin, then limit and homing triggers
    alarm_active_i <= 1'b1;
    pin_r.alarm_reset <= 1'b1;
    fbus_i.position_error_reset <= 1'b1;
    st(4);
    chk(drv_o.alarm_reset, 1'b1, "alarm pin");
    pin_r.alarm_reset <= 1'b0;
    st(4);
    chk(drv_o.alarm_reset, 1'b0, "deviation hidden");
    alarm_active_i <= 1'b0;
    st(2);
    chk(drv_o.alarm_reset, 1'b1, "deviation shown");
    fbus_i <= '0;
    st(2);
    n0 = clr;
    pin_r.limit_positive <= 1'b1;
    st(8);
    chk(clr - n0, DEVIATION_CLEAR_OUT, "limit clear");
    pin_r.limit_positive <= 1'b0;
    wr(mdol_pkg::ADDR_CTRL, 32'h45);
    n0 = clr;
    pin_r.limit_negative <= 1'b1;
    st(8);
    chk(clr - n0, 0, "limit ignored");
    wr(mdol_pkg::ADDR_CTRL, 32'h85);
    n0 = clr;
    homing_active_i <= 1'b1;
    st(8);
    chk(clr - n0, DEVIATION_CLEAR_OUT, "homing clear");
    // position readout through the driver model
    wr(mdol_pkg::ADDR_CTRL, 32'h5);
    n0 = rs;
    wr(mdol_pkg::ADDR_CMD, 32'h8);
    st(0);
    chk(drv_o.position_request, 1'b1, "request");
    rd(mdol_pkg::ADDR_STATUS, d);
    chk(d[8:6], 3'h0, "pins hidden");
    wait_low(1);
    rd(mdol_pkg::ADDR_POSITION, d);
    chk(d, 32'hb, "position word");
    chk(drv_o.position_request, 1'b0, "request dropped");
    chk(rs - n0, 2, "strobes");
    wr(mdol_pkg::ADDR_CMD, 32'h10);
    wait_low(1);
    rd(mdol_pkg::ADDR_POSITION, d);
    chk(d, 32'hbb, "read set word");
    close_out();
  end
endmodule : tb
`default_nettype wire

// >>> verilog/mdol_motor_driver_output_logic.sv
// mdol_motor_driver_output_logic: step generator and driver control outputs
// Summary of operation
// - single format: steps on one pin, direction high for clockwise.
// - dual format: clockwise and counter-clockwise steps on separate pins.
// - format bit 0 selects dual, 1 selects single; resets to 1.
// - a control bit inverts polarity of both step pins.
// - step duty is half; at 25 kHz or slower, on-time fixed 20 us.
// - current off when enable pin, current command or fieldbus asks.
// - current on output is always the inverse of current off.
// - without an assigned enable pin a startup setting picks initial current.
// - clear output resets alarms when alarmed, else clears deviation counter.
// - deviation clear pulses on limit trip, panic halt, homing start.
// - resolution output fixed at power-up from a startup setting.
// - free output on when free pin or fieldbus free bit is on.
// - free command drives free output regardless of the free inputs.
// - sensorless home start works only with homing type 12; separate halt.
// - position request asserted during readout; readout pins work only then.
// - outside readout the strobe pin carries a general-purpose output.
// - torque limit on from its pin or from its command bit.
// - brake released when current on or free; locked only when both off.
// - both brake outputs always carry the same state.
// - preset output tells the driver to load home as current position.
// - general output eight follows its command bit.
// - readout inputs are general inputs except while a readout runs.
`default_nettype none
module mdol_motor_driver_output_logic #(
  parameter int DCL_WIDTH       = 10,
  parameter int RD_HALF         = 5,
  parameter int RD_PAIRS        = 16,
  parameter bit STARTUP_CURRENT = 1'b1,
  parameter bit STARTUP_RES     = 1'b0
) (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // register port
  input  wire logic [7:0]            addr_i,
  input  wire logic [31:0]           wdata_i,
  input  wire logic                  we_i,
  input  wire logic                  re_i,
  output logic [31:0]                rdata_o,
  // connector and fieldbus inputs
  input  wire mdol_pkg::mdol_pin_in_t  pins_i,
  input  wire mdol_pkg::mdol_bus_req_t fbus_i,
  input  wire logic                  alarm_active_i,
  input  wire logic                  homing_active_i,
  // driver outputs
  output mdol_pkg::mdol_drv_out_t    drv_o
);

  localparam logic [15:0] CTRL_RST =
    mdol_pkg::CTRL_RESET | (16'(STARTUP_CURRENT) << mdol_pkg::CTRL_CUR_CMD);
  localparam logic [7:0]  DCLW     = 8'(DCL_WIDTH);
  localparam logic [7:0]  HALF_END = 8'(RD_HALF - 1);
  localparam logic [7:0]  PAIR_END = 8'(RD_PAIRS - 1);
  localparam logic [15:0] ON_CYC16 = 16'(mdol_pkg::ON_CYC);
  localparam logic [15:0] SLOW16   = 16'(mdol_pkg::SLOW_PERIOD_CYC);
  localparam logic [7:0]  HOME12   = 8'(mdol_pkg::HOMING_SENSORLESS);

  typedef struct packed {
    mdol_pkg::mdol_pin_in_t   sync1;
    mdol_pkg::mdol_pin_in_t   sync2;
    logic                     lim_prev;
    logic                     hom_prev;
    logic [15:0]              ctrl;
    logic [15:0]              rate;
    logic [7:0]               homing;
    logic [15:0]              steps;
    logic                     dir;
    logic [15:0]              pcnt;
    logic [7:0]               alm_cnt;
    logic [7:0]               dcl_cnt;
    mdol_pkg::mdol_rd_state_t rd;
    logic [7:0]               rd_cnt;
    logic [7:0]               rd_pairs;
    logic [31:0]              pos;
    logic                     rd_done;
    logic [31:0]              rdata;
    mdol_pkg::mdol_drv_out_t  out;
  } mdol_state_t;

  mdol_state_t q_r;
  mdol_state_t q_nxt;

  // period below two cycles cannot hold a high and a low phase
  function automatic logic [15:0] mdol_eff_period(input logic [15:0] r);
    mdol_eff_period = (r < 16'h0002) ? 16'h0002 : r;
  endfunction : mdol_eff_period

  // fixed on-time at slow rates, half period otherwise
  function automatic logic [15:0] mdol_on_time(input logic [15:0] p);
    mdol_on_time = (p >= SLOW16) ? ON_CYC16 : (p >> 1);
  endfunction : mdol_on_time

  logic [4:0]  cmd_w;
  logic        move_w;
  logic [15:0] per;
  logic        pulse;
  logic        single;
  logic        inv;
  logic        lim_now;
  logic        dcl_evt;
  logic        current_off_out;
  logic        free_st;
  logic        req_busy;
  logic [2:0]  gp_in;

  // command strobes and derived terms
  assign cmd_w   = (we_i && addr_i == mdol_pkg::ADDR_CMD) ? wdata_i[4:0] : 5'h00;
  assign move_w  = we_i && addr_i == mdol_pkg::ADDR_MOVE;
  assign per     = mdol_eff_period(q_r.rate);
  assign pulse   = (q_r.steps != 16'h0000) && (q_r.pcnt < mdol_on_time(per));
  assign single  = q_r.ctrl[mdol_pkg::CTRL_PULSE_FMT];
  assign inv     = q_r.ctrl[mdol_pkg::CTRL_POL_INV];
  assign lim_now = q_r.sync2.limit_positive | q_r.sync2.limit_negative;
  // deviation clear triggers; homing clear fires once at homing start
  assign dcl_evt = cmd_w[mdol_pkg::CMD_PE_RESET] | cmd_w[mdol_pkg::CMD_PANIC]
                 | (lim_now & ~q_r.lim_prev & ~q_r.ctrl[mdol_pkg::CTRL_OT_ACTION])
                 | (homing_active_i & ~q_r.hom_prev & q_r.ctrl[mdol_pkg::CTRL_HOME_DCL]);
  // any single source asking for current off wins
  assign current_off_out    = (q_r.ctrl[mdol_pkg::CTRL_CEN_ASSIGN] & ~q_r.sync2.current_enable)
                 | ~q_r.ctrl[mdol_pkg::CTRL_CUR_CMD] | fbus_i.current_off;
  assign free_st = q_r.sync2.free | fbus_i.free | q_r.ctrl[mdol_pkg::CTRL_FREE_CMD];
  assign req_busy = q_r.rd != mdol_pkg::RD_IDLE;
  // shared pins read as general inputs only while no readout runs
  assign gp_in   = req_busy ? 3'h0 : {q_r.sync2.readout_ready_in,
                   q_r.sync2.position_bit_one, q_r.sync2.position_bit_zero};

  // next state of the whole block
  always_comb begin
    q_nxt = q_r;
    q_nxt.rdata = 32'h0000_0000;
    // two-stage synchroniser for every connector pin
    q_nxt.sync1 = pins_i;
    q_nxt.sync2 = q_r.sync1;
    q_nxt.lim_prev = lim_now;
    q_nxt.hom_prev = homing_active_i;

    // register writes
    if (we_i) begin
      if (addr_i == mdol_pkg::ADDR_CTRL) begin
        q_nxt.ctrl = wdata_i[15:0];
      end else if (addr_i == mdol_pkg::ADDR_RATE) begin
        q_nxt.rate = wdata_i[15:0];
      end else if (addr_i == mdol_pkg::ADDR_HOMING) begin
        q_nxt.homing = wdata_i[7:0];
      end
    end

    // register reads, answered in the following cycle
    if (re_i) begin
      if (addr_i == mdol_pkg::ADDR_CTRL) begin
        q_nxt.rdata = {16'h0000, q_r.ctrl};
      end else if (addr_i == mdol_pkg::ADDR_RATE) begin
        q_nxt.rdata = {16'h0000, q_r.rate};
      end else if (addr_i == mdol_pkg::ADDR_HOMING) begin
        q_nxt.rdata = {24'h00_0000, q_r.homing};
      end else if (addr_i == mdol_pkg::ADDR_STATUS) begin
        q_nxt.rdata = {q_r.steps, 7'h00, gp_in, q_r.out.free, q_r.out.current_on,
                       alarm_active_i, q_r.rd_done, req_busy, q_r.steps != 16'h0000};
        q_nxt.rd_done = 1'b0;
      end else if (addr_i == mdol_pkg::ADDR_POSITION) begin
        q_nxt.rdata = q_r.pos;
      end
    end

    // step sequencer; a move written while busy is dropped
    if (q_r.steps != 16'h0000) begin
      if (q_r.pcnt >= per - 16'h0001) begin
        q_nxt.pcnt  = 16'h0000;
        q_nxt.steps = q_r.steps - 16'h0001;
      end else begin
        q_nxt.pcnt = q_r.pcnt + 16'h0001;
      end
    end else if (move_w) begin
      q_nxt.steps = wdata_i[15:0];
      q_nxt.dir   = wdata_i[mdol_pkg::MOVE_DIR];
      q_nxt.pcnt  = 16'h0000;
    end

    // clear pulse timers; a new trigger restarts the full width
    if (cmd_w[mdol_pkg::CMD_ALM_RESET]) begin
      q_nxt.alm_cnt = DCLW;
    end else if (q_r.alm_cnt != 8'h00) begin
      q_nxt.alm_cnt = q_r.alm_cnt - 8'h01;
    end
    if (dcl_evt) begin
      q_nxt.dcl_cnt = DCLW;
    end else if (q_r.dcl_cnt != 8'h00) begin
      q_nxt.dcl_cnt = q_r.dcl_cnt - 8'h01;
    end

    // readout sequencer: request, wait ready, then strobe out bit pairs
    case (q_r.rd)
      mdol_pkg::RD_IDLE: begin
        if (cmd_w[mdol_pkg::CMD_READ_POS] | cmd_w[mdol_pkg::CMD_READ_SET]) begin
          q_nxt.rd       = mdol_pkg::RD_WAIT;
          q_nxt.rd_pairs = 8'h00;
          q_nxt.rd_cnt   = 8'h00;
        end
      end
      mdol_pkg::RD_WAIT: begin
        if (q_r.sync2.readout_ready_in) begin
          q_nxt.rd = mdol_pkg::RD_HIGH;
        end
      end
      mdol_pkg::RD_HIGH: begin
        if (q_r.rd_cnt == HALF_END) begin
          q_nxt.rd     = mdol_pkg::RD_LOW;
          q_nxt.rd_cnt = 8'h00;
          q_nxt.pos    = {q_r.pos[29:0], q_r.sync2.position_bit_one,
                          q_r.sync2.position_bit_zero};
        end else begin
          q_nxt.rd_cnt = q_r.rd_cnt + 8'h01;
        end
      end
      mdol_pkg::RD_LOW: begin
        if (q_r.rd_cnt == HALF_END) begin
          q_nxt.rd_cnt = 8'h00;
          if (q_r.rd_pairs == PAIR_END) begin
            q_nxt.rd      = mdol_pkg::RD_IDLE;
            q_nxt.rd_done = 1'b1; // set beats the read-clear
          end else begin
            q_nxt.rd       = mdol_pkg::RD_HIGH;
            q_nxt.rd_pairs = q_r.rd_pairs + 8'h01;
          end
        end else begin
          q_nxt.rd_cnt = q_r.rd_cnt + 8'h01;
        end
      end
      default: begin
        q_nxt.rd = mdol_pkg::RD_IDLE;
      end
    endcase

    // step pins
    q_nxt.out.step_a = inv ^ (single ? pulse : (pulse & q_r.dir));
    q_nxt.out.step_b = inv ^ (single ? q_r.dir : (pulse & ~q_r.dir));
    // current, free and brake share one decision so they never disagree
    q_nxt.out.current_off = current_off_out;
    q_nxt.out.current_on  = ~current_off_out;
    q_nxt.out.free        = free_st;
    q_nxt.out.brake_drv   = ~current_off_out | free_st;
    q_nxt.out.brake_io    = ~current_off_out | free_st;
    // one pin: alarm reset while alarmed, deviation clear otherwise
    q_nxt.out.alarm_reset = alarm_active_i ?
      (q_r.sync2.alarm_reset | fbus_i.alarm_reset | (q_r.alm_cnt != 8'h00)) :
      (q_r.sync2.position_error_reset | fbus_i.position_error_reset |
       (q_r.dcl_cnt != 8'h00));
    // level outputs steered by control bits
    q_nxt.out.home_start = q_nxt.ctrl[mdol_pkg::CTRL_HOME_START] &&
                           q_nxt.homing == HOME12;
    q_nxt.out.home_halt  = q_nxt.ctrl[mdol_pkg::CTRL_HOME_HALT];
    q_nxt.out.preset     = q_nxt.ctrl[mdol_pkg::CTRL_PRESET];
    q_nxt.out.torque_limit = q_r.sync2.torque_limit |
                             q_nxt.ctrl[mdol_pkg::CTRL_TL_CMD];
    q_nxt.out.general_eight = q_nxt.ctrl[mdol_pkg::CTRL_GENERAL_OUTPUT_EIGHT];
    q_nxt.out.position_request = q_nxt.rd != mdol_pkg::RD_IDLE;
    q_nxt.out.shift_strobe = q_nxt.out.position_request ? (q_nxt.rd == mdol_pkg::RD_HIGH) :
                             q_nxt.ctrl[mdol_pkg::CTRL_GP_STROBE];
  end

  // state register; resolution is fixed here and never rewritten
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_r                  <= '0;
      q_r.ctrl             <= CTRL_RST;
      q_r.rate             <= mdol_pkg::RATE_RESET;
      q_r.homing           <= mdol_pkg::HOMING_RESET;
      q_r.out.current_on   <= STARTUP_CURRENT;
      q_r.out.current_off  <= ~STARTUP_CURRENT;
      q_r.out.brake_drv    <= STARTUP_CURRENT;
      q_r.out.brake_io     <= STARTUP_CURRENT;
      q_r.out.resolution   <= STARTUP_RES;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign rdata_o = q_r.rdata;
  assign drv_o   = q_r.out;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_current_inverse: assert property (drv_o.current_on == ~drv_o.current_off)
    else $error("current on is not the inverse of current off");
  a_current_fbus: assert property (fbus_i.current_off |=> drv_o.current_off)
    else $error("fieldbus current off not honoured");
  a_brake_match: assert property (drv_o.brake_drv == drv_o.brake_io)
    else $error("brake outputs differ");
  a_brake_law: assert property (drv_o.brake_io == (drv_o.current_on | drv_o.free))
    else $error("brake state wrong for current and free");
  a_free_fbus: assert property (fbus_i.free |=> drv_o.free)
    else $error("fieldbus free not honoured");
  a_free_cmd: assert property (q_r.ctrl[mdol_pkg::CTRL_FREE_CMD] |=> drv_o.free)
    else $error("free command ignored");
  a_res_hold: assert property ($stable(drv_o.resolution))
    else $error("resolution output changed");
  a_home_type: assert property (drv_o.home_start |-> q_r.homing == HOME12)
    else $error("home start without homing type 12");
  a_strobe_gp: assert property (!drv_o.position_request |->
      drv_o.shift_strobe == q_r.ctrl[mdol_pkg::CTRL_GP_STROBE])
    else $error("strobe pin not general output outside readout");
  a_strobe_req: assert property (drv_o.shift_strobe && q_r.rd == mdol_pkg::RD_HIGH
      |-> drv_o.position_request)
    else $error("readout strobe without request");
  a_panic_clear: assert property (cmd_w[mdol_pkg::CMD_PANIC] |=> q_r.dcl_cnt == DCLW)
    else $error("panic halt did not start deviation clear");
  a_clear_drive: assert property (q_r.dcl_cnt != 8'h00 && !alarm_active_i
      |=> drv_o.alarm_reset)
    else $error("deviation clear pulse missing");
  a_torque_pin: assert property (q_r.sync2.torque_limit |=> drv_o.torque_limit)
    else $error("torque limit pin ignored");
  a_slow_ontime: assert property (q_r.steps != 16'h0000 && per >= SLOW16 && single
      && !inv && q_r.pcnt == ON_CYC16 - 16'h0001 |=> drv_o.step_a ##1 !drv_o.step_a)
    else $error("slow step on-time not fixed");
  a_dual_excl: assert property (!single && !inv |=> !(drv_o.step_a && drv_o.step_b))
    else $error("both dual step pins high");
  a_single_dir: assert property (single && q_r.steps != 16'h0000
      |=> drv_o.step_b == $past(q_r.dir ^ inv))
    else $error("direction pin wrong in single format");

  // clear pin sources and the clear timer
  a_alarm_clear: assert property (
      alarm_active_i && q_r.alm_cnt != 8'h00 |=> drv_o.alarm_reset)
    else $error("alarm reset pulse missing");

  a_dev_hidden: assert property (
      alarm_active_i && q_r.alm_cnt == 8'h00 && !q_r.sync2.alarm_reset
      && !fbus_i.alarm_reset |=> !drv_o.alarm_reset)
    else $error("deviation clear shown during alarm");

  a_limit_clear: assert property (
      lim_now && !q_r.lim_prev && !q_r.ctrl[mdol_pkg::CTRL_OT_ACTION]
      |=> q_r.dcl_cnt == DCLW)
    else $error("limit trip did not start deviation clear");

  a_home_clear: assert property (
      homing_active_i && !q_r.hom_prev && q_r.ctrl[mdol_pkg::CTRL_HOME_DCL]
      |=> q_r.dcl_cnt == DCLW)
    else $error("homing did not start deviation clear");

  // the clear timer counts down one step a cycle
  a_clear_width: assert property (
      q_r.dcl_cnt != 8'h00 && !dcl_evt |=> q_r.dcl_cnt == $past(q_r.dcl_cnt) - 8'h01)
    else $error("clear timer did not count down");

  // readout start
  a_read_start: assert property (
      q_r.rd == mdol_pkg::RD_IDLE && cmd_w[mdol_pkg::CMD_READ_POS]
      |=> drv_o.position_request)
    else $error("read command did not raise request");

  // level outputs track their control bits cycle for cycle
  a_eight_level: assert property (
      drv_o.general_eight == q_r.ctrl[mdol_pkg::CTRL_GENERAL_OUTPUT_EIGHT])
    else $error("general output eight differs from its bit");

  a_preset_level: assert property (
      drv_o.preset == q_r.ctrl[mdol_pkg::CTRL_PRESET])
    else $error("preset output differs from its bit");

  a_halt_level: assert property (
      drv_o.home_halt == q_r.ctrl[mdol_pkg::CTRL_HOME_HALT])
    else $error("home halt output differs from its bit");

  // dual format clockwise steps on the first pin only
  a_dual_cw: assert property (
      !single && !inv && pulse && q_r.dir |=> drv_o.step_a && !drv_o.step_b)
    else $error("clockwise dual step on wrong pin");

endmodule : mdol_motor_driver_output_logic
`default_nettype wire

// >>> verilog/mdol_pkg.sv
// mdol_pkg: constants and carrier types for the motor driver output logic
`default_nettype none
package mdol_pkg;
  // timing
  localparam int CLK_HZ          = 10_000_000;
  localparam int CLK_PERIOD_NS   = 100;
  localparam int ON_TIME_NS      = 20_000;
  localparam int SLOW_RATE_HZ    = 25_000;
  localparam int ON_CYC          = (ON_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLOW_PERIOD_CYC = CLK_HZ / SLOW_RATE_HZ;
  localparam int HOMING_SENSORLESS = 12;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_RATE     = 8'h04;
  localparam logic [7:0] ADDR_MOVE     = 8'h08;
  localparam logic [7:0] ADDR_CMD      = 8'h0c;
  localparam logic [7:0] ADDR_HOMING   = 8'h10;
  localparam logic [7:0] ADDR_STATUS   = 8'h14;
  localparam logic [7:0] ADDR_POSITION = 8'h18;

  // control register fields
  localparam int CTRL_PULSE_FMT  = 0;
  localparam int CTRL_POL_INV    = 1;
  localparam int CTRL_CUR_CMD    = 2;
  localparam int CTRL_FREE_CMD   = 3;
  localparam int CTRL_TL_CMD     = 4;
  localparam int CTRL_GENERAL_OUTPUT_EIGHT       = 5;
  localparam int CTRL_OT_ACTION  = 6;
  localparam int CTRL_HOME_DCL   = 7;
  localparam int CTRL_CEN_ASSIGN = 8;
  localparam int CTRL_HOME_START = 9;
  localparam int CTRL_HOME_HALT  = 10;
  localparam int CTRL_PRESET     = 11;
  localparam int CTRL_GP_STROBE  = 12;
  localparam logic [15:0] CTRL_RESET = 16'h0001;

  // command register fields (write-only pulses)
  localparam int CMD_ALM_RESET = 0;
  localparam int CMD_PE_RESET  = 1;
  localparam int CMD_PANIC     = 2;
  localparam int CMD_READ_POS  = 3;
  localparam int CMD_READ_SET  = 4;

  // move register fields
  localparam int MOVE_DIR = 16;

  // reset values
  localparam logic [15:0] RATE_RESET   = 16'h03e8;
  localparam logic [7:0]  HOMING_RESET = 8'h00;

  // readout sequencer states
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_WAIT = 2'b01,
    RD_HIGH = 2'b10,
    RD_LOW  = 2'b11
  } mdol_rd_state_t;

  // connector inputs (asynchronous pins)
  typedef struct packed {
    logic current_enable;
    logic alarm_reset;
    logic position_error_reset;
    logic free;
    logic torque_limit;
    logic limit_positive;
    logic limit_negative;
    logic readout_ready_in;
    logic position_bit_zero;
    logic position_bit_one;
  } mdol_pin_in_t;

  // fieldbus requests (same clock)
  typedef struct packed {
    logic current_off;
    logic alarm_reset;
    logic position_error_reset;
    logic free;
  } mdol_bus_req_t;

  // outputs toward the driver
  typedef struct packed {
    logic step_a;
    logic step_b;
    logic current_off;
    logic current_on;
    logic alarm_reset;
    logic resolution;
    logic free;
    logic home_start;
    logic home_halt;
    logic position_request;
    logic preset;
    logic shift_strobe;
    logic torque_limit;
    logic brake_drv;
    logic brake_io;
    logic general_eight;
  } mdol_drv_out_t;
endpackage : mdol_pkg
`default_nettype wire
